// ### rtl/serial_port_pkg.sv
package serial_port_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 4;
  localparam int SHIFT_W = 8;
  localparam int CNT_W   = 3;

  // register addresses
  localparam logic [7:0] ADDR_PIN_FUNC = 8'h04;
  localparam logic [7:0] ADDR_MODE_A   = 8'h05;
  localparam logic [7:0] ADDR_DATA_LO  = 8'h06;
  localparam logic [7:0] ADDR_DATA_HI  = 8'h07;
  localparam logic [7:0] ADDR_MISC     = 8'h0C;
  localparam logic [7:0] ADDR_MODE_B   = 8'h28;
  localparam logic [7:0] ADDR_START    = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h31;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;

  // field positions
  localparam int MODEB_DIV_BIT  = 0;
  localparam int MODEB_IDLE_BIT = 1;
  localparam int PIN_SO_BIT     = 0;
  localparam int PIN_SI_BIT     = 1;
  localparam int MISC_PMOS_BIT  = 2;
  localparam int IRQ_DONE_BIT   = 0;

  // reset values
  localparam logic [1:0] PIN_FUNC_RST = 2'h0;
  localparam logic [3:0] MISC_RST     = 4'h0;
  localparam logic       DIV_SEL_RST  = 1'h0;
  localparam logic       IDLE_RST     = 1'h0;
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam logic [3:0] STAT_RST     = 4'h0;
  localparam logic [2:0] CNT_RST      = 3'h0;
  localparam logic [3:0] RD_ZERO      = 4'h0;

  // transfer clock half period, in prescaler ticks minus one
  localparam logic HALF_DIV2 = 1'h0;
  localparam logic HALF_DIV4 = 1'h1;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } xfer_state_t;

endpackage

// ### rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = ce ? d : meta_ff;
    nxt_q    = ce ? meta_ff : q_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff    <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule

// ### rtl/xfer_clock_div.sv
`timescale 1ns/1ps
module xfer_clock_div (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic tick,
  input  wire logic div4,
  output logic      toggle
);

  logic cnt_ff;
  logic nxt_cnt;
  logic term;

  always_comb begin
    term    = div4 ? serial_port_pkg::HALF_DIV4 : serial_port_pkg::HALF_DIV2;
    nxt_cnt = cnt_ff;
    toggle  = 1'b0;
    if (!run) begin
      nxt_cnt = 1'b0;
    end else if (tick) begin
      if (cnt_ff == term) begin
        nxt_cnt = 1'b0;
        toggle  = ce;
      end else begin
        nxt_cnt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  div4_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    run && tick && div4 && cnt_ff == 1'b0 |-> !toggle)
    else $error("divide by four toggled after one tick");

endmodule

// ### rtl/clocked_serial_port_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - divisor bit picks prescaler output over two (0) or four (1)
// - reset clears both mode B bits; stop mode clears the divisor select bit, not the idle level
// - idle serial output follows the idle level bit one clock later
// - idle level bit has no defined value after reset or stop; here reset loads 0 and stop keeps it
// - transmit data leave LSB first, changing on transfer clock fall
// - serial input sampled on transfer clock rise, LSB first
// - serial data is two read/write four-bit digits, undefined at reset
// - pin function bits pick serial in (bit 1), serial out (bit 0)
// - misc bit 2 low enables output PMOS, high gives open drain
// - misc register cleared by reset and by stop mode
// - three-bit counter wraps after eighth clock, sets flag, ends transfer
// - mode A write stops clock, clears counter, flags if mid-transfer
module clocked_serial_port_regs (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       stop_mode,
  input  wire logic       prescaler_tick,
  input  wire logic [7:0] addr,
  input  wire logic [3:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [3:0] rd_data,
  output logic            serial_clock_pin,
  input  wire logic       serial_input_pin,
  output logic            serial_output_pin,
  output logic            serial_output_pin_oe,
  output logic            busy,
  output logic            irq
);

  // register state
  logic [1:0] pin_func_ff;
  logic [3:0] misc_ff;
  logic       div_sel_ff;
  logic       idle_lvl_ff;
  logic [3:0] mask_ff;
  logic [3:0] stat_ff;
  logic [3:0] rd_data_ff;
  logic       irq_ff;
  logic [1:0] nxt_pin_func;
  logic [3:0] nxt_misc;
  logic       nxt_div_sel;
  logic       nxt_idle_lvl;
  logic [3:0] nxt_mask;
  logic [3:0] nxt_stat;
  logic [3:0] nxt_rd_data;
  logic       nxt_irq;

  // transfer state
  serial_port_pkg::xfer_state_t state_ff;
  serial_port_pkg::xfer_state_t nxt_state;
  logic [7:0] shreg_ff;
  logic [2:0] cnt_ff;
  logic       sck_ff;
  logic       so_bit_ff;
  logic       so_out_ff;
  logic       so_oe_ff;
  logic [7:0] nxt_shreg;
  logic [2:0] nxt_cnt;
  logic       nxt_sck;
  logic       nxt_so_bit;
  logic       nxt_so_out;
  logic       nxt_so_oe;

  logic       si_sync;
  logic       toggle;
  logic       wr_mode_a;
  logic       done_evt;
  logic       xfer;
  logic       so_level;
  logic       pmos_off;

  assign xfer      = (state_ff == serial_port_pkg::ST_XFER);
  assign wr_mode_a = wr_en && addr == serial_port_pkg::ADDR_MODE_A;

  level_sync #(.W(1)) u_si_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (serial_input_pin),
    .q     (si_sync)
  );

  xfer_clock_div u_div (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .run    (xfer && !wr_mode_a && !stop_mode),
    .tick   (prescaler_tick),
    .div4   (div_sel_ff),
    .toggle (toggle)
  );

  // register file
  always_comb begin
    nxt_pin_func = pin_func_ff;
    nxt_misc     = misc_ff;
    nxt_div_sel  = div_sel_ff;
    nxt_idle_lvl = idle_lvl_ff;
    nxt_mask     = mask_ff;
    nxt_rd_data  = serial_port_pkg::RD_ZERO;
    nxt_stat     = stat_ff;
    if (rd_en && addr == serial_port_pkg::ADDR_IRQ_STAT) begin
      nxt_stat = serial_port_pkg::STAT_RST;
    end
    // set wins over the read clear
    if (done_evt) begin
      nxt_stat[serial_port_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (wr_en) begin
      case (addr)
        serial_port_pkg::ADDR_PIN_FUNC: nxt_pin_func = wr_data[1:0];
        serial_port_pkg::ADDR_MISC:     nxt_misc = wr_data;
        serial_port_pkg::ADDR_IRQ_MASK: nxt_mask = wr_data;
        serial_port_pkg::ADDR_MODE_B: begin
          // ignored mid-transfer so the shift clock rate cannot jump
          if (!xfer) begin
            nxt_div_sel  = wr_data[serial_port_pkg::MODEB_DIV_BIT];
            nxt_idle_lvl = wr_data[serial_port_pkg::MODEB_IDLE_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        serial_port_pkg::ADDR_DATA_LO:  nxt_rd_data = shreg_ff[3:0];
        serial_port_pkg::ADDR_DATA_HI:  nxt_rd_data = shreg_ff[7:4];
        serial_port_pkg::ADDR_IRQ_STAT: nxt_rd_data = stat_ff;
        serial_port_pkg::ADDR_IRQ_MASK: nxt_rd_data = mask_ff;
        default:                        nxt_rd_data = serial_port_pkg::RD_ZERO;
      endcase
    end
    if (stop_mode) begin
      nxt_pin_func = serial_port_pkg::PIN_FUNC_RST;
      nxt_misc     = serial_port_pkg::MISC_RST;
      nxt_div_sel  = serial_port_pkg::DIV_SEL_RST;
    end
    nxt_irq = |(nxt_stat & mask_ff);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_func_ff <= serial_port_pkg::PIN_FUNC_RST;
      misc_ff     <= serial_port_pkg::MISC_RST;
      div_sel_ff  <= serial_port_pkg::DIV_SEL_RST;
      // idle level has no documented reset; a known value keeps pins clean
      idle_lvl_ff <= serial_port_pkg::IDLE_RST;
      mask_ff     <= serial_port_pkg::MASK_RST;
      stat_ff     <= serial_port_pkg::STAT_RST;
      rd_data_ff  <= serial_port_pkg::RD_ZERO;
      irq_ff      <= 1'b0;
    end else if (ce) begin
      pin_func_ff <= nxt_pin_func;
      misc_ff     <= nxt_misc;
      div_sel_ff  <= nxt_div_sel;
      idle_lvl_ff <= nxt_idle_lvl;
      mask_ff     <= nxt_mask;
      stat_ff     <= nxt_stat;
      rd_data_ff  <= nxt_rd_data;
      irq_ff      <= nxt_irq;
    end
  end

  // transfer engine, internal clock only
  always_comb begin
    nxt_state  = state_ff;
    nxt_shreg  = shreg_ff;
    nxt_cnt    = cnt_ff;
    nxt_sck    = sck_ff;
    nxt_so_bit = so_bit_ff;
    done_evt   = 1'b0;
    if (wr_en && !xfer) begin
      // data digits are left alone mid-transfer; no guarantee anyway
      if (addr == serial_port_pkg::ADDR_DATA_LO) begin
        nxt_shreg[3:0] = wr_data;
      end
      if (addr == serial_port_pkg::ADDR_DATA_HI) begin
        nxt_shreg[7:4] = wr_data;
      end
    end
    case (state_ff)
      serial_port_pkg::ST_IDLE: begin
        nxt_sck = 1'b1;
        if (wr_en && addr == serial_port_pkg::ADDR_START && !stop_mode) begin
          nxt_state = serial_port_pkg::ST_XFER;
          nxt_cnt   = serial_port_pkg::CNT_RST;
        end
      end
      serial_port_pkg::ST_XFER: begin
        if (wr_mode_a || stop_mode) begin
          nxt_state = serial_port_pkg::ST_IDLE;
          nxt_cnt   = serial_port_pkg::CNT_RST;
          nxt_sck   = 1'b1;
          done_evt  = 1'b1;
        end else if (toggle) begin
          nxt_sck = !sck_ff;
          if (sck_ff) begin
            nxt_so_bit = shreg_ff[0];
          end else begin
            nxt_shreg = {si_sync && pin_func_ff[serial_port_pkg::PIN_SI_BIT],
                         shreg_ff[7:1]};
            nxt_cnt   = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              nxt_state = serial_port_pkg::ST_IDLE;
              done_evt  = 1'b1;
            end
          end
        end
      end
      default: nxt_state = serial_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff  <= serial_port_pkg::ST_IDLE;
      cnt_ff    <= serial_port_pkg::CNT_RST;
      sck_ff    <= 1'b1;
      so_bit_ff <= 1'b1;
    end else if (ce) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      sck_ff    <= nxt_sck;
      so_bit_ff <= nxt_so_bit;
    end
  end

  // serial data carry no reset by design
  always_ff @(posedge clk) begin
    if (ce) begin
      shreg_ff <= nxt_shreg;
    end
  end

  // output pin drive
  assign pmos_off = misc_ff[serial_port_pkg::MISC_PMOS_BIT];

  always_comb begin
    so_level   = xfer ? so_bit_ff : idle_lvl_ff;
    nxt_so_out = so_level;
    nxt_so_oe  = 1'b0;
    if (pin_func_ff[serial_port_pkg::PIN_SO_BIT]) begin
      // with the pull-up transistor off only a low is driven
      nxt_so_oe = pmos_off ? !so_level : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      so_out_ff <= 1'b0;
      so_oe_ff  <= 1'b0;
    end else if (ce) begin
      so_out_ff <= nxt_so_out;
      so_oe_ff  <= nxt_so_oe;
    end
  end

  assign rd_data              = rd_data_ff;
  assign serial_clock_pin     = sck_ff;
  assign serial_output_pin    = so_out_ff;
  assign serial_output_pin_oe = so_oe_ff;
  assign busy                 = state_ff == serial_port_pkg::ST_XFER;
  assign irq                  = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  stop_div_clr_a: assert property (ce && stop_mode |=> !div_sel_ff)
    else $error("stop mode left divisor select set");
  stop_misc_clr_a: assert property (ce && stop_mode |=> misc_ff == 4'h0)
    else $error("stop mode left misc register set");
  stop_pin_clr_a: assert property (ce && stop_mode |=> pin_func_ff == 2'h0)
    else $error("stop mode left pin function set");
  idle_level_a: assert property (ce && !xfer && !busy
    |=> so_out_ff == $past(idle_lvl_ff))
    else $error("idle output does not follow idle level");
  lsb_out_a: assert property (ce && xfer && toggle && sck_ff
    && !wr_mode_a && !stop_mode |=> so_bit_ff == $past(shreg_ff[0]))
    else $error("transmit bit is not the low bit");
  msb_in_a: assert property (ce && xfer && toggle && !sck_ff
    && !wr_mode_a && !stop_mode
    |=> shreg_ff[7] == ($past(si_sync) && $past(pin_func_ff[1])))
    else $error("received bit not shifted in at the top");
  wrap_done_a: assert property (ce && xfer && toggle && !sck_ff
    && cnt_ff == 3'h7 && !wr_mode_a && !stop_mode
    |=> !busy && stat_ff[0] && cnt_ff == 3'h0)
    else $error("eighth clock did not end the transfer");
  abort_flag_a: assert property (ce && xfer && wr_mode_a
    |=> !busy && cnt_ff == 3'h0 && stat_ff[0])
    else $error("mode A write did not abort and flag");
  open_drain_a: assert property (pmos_off && so_oe_ff
    && $stable(pmos_off) |-> !so_out_ff)
    else $error("high driven while pull-up is off");

  xfer_done_c: cover property (done_evt && !wr_mode_a);
  abort_c: cover property (xfer && wr_mode_a);
  irq_c: cover property (irq);

endmodule

// ### bench/serial_peer_model.sv
`timescale 1ns/1ps
module serial_peer_model (
  input  wire logic        clk,
  input  wire logic        sck,
  input  wire logic        so,
  input  wire logic        arm,
  input  wire logic [7:0]  tx_byte,
  output logic             si,
  output logic [7:0]       rx_byte,
  output logic [15:0]      period
);
  logic        sck_q;
  logic [15:0] cnt;
  logic [2:0]  idx;
  initial begin
    sck_q = 1'h1;
    cnt = 16'h0;
    idx = 3'h0;
    si = 1'h0;
    rx_byte = 8'h0;
    period = 16'h0;
  end
  always @(posedge clk) begin
    sck_q <= sck;
    cnt <= cnt + 16'h1;
    // undriven line has no pull: show the inverse of the last bit
    if (arm) begin
      idx <= 3'h0;
      si <= ~si;
    end
    if (sck && !sck_q) begin  // first bit ends lowest
      rx_byte <= {so, rx_byte[7:1]};
      period <= cnt;
      cnt <= 16'h1;
    end
    if (!sck && sck_q) begin  // new bit after each fall, LSB first
      si <= tx_byte[idx];
      idx <= idx + 3'h1;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, ce, stop_mode, prescaler_tick, wr_en, rd_en, arm;
  logic [7:0]  addr, ptx, prx;
  logic [3:0]  wr_data, rd_data, d, lo;
  logic        sck, so, so_oe, busy, irq, si, so_wire;
  logic [15:0] period;
  logic [2:0]  pc;
  int          num_errors, samples_checked;

  clocked_serial_port_regs i_clocked_serial_port_regs (
    .clk                  (clk),
    .rst_n                (rst_n),
    .ce                   (ce),
    .stop_mode            (stop_mode),
    .prescaler_tick       (prescaler_tick),
    .addr                 (addr),
    .wr_data              (wr_data),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rd_data              (rd_data),
    .serial_clock_pin     (sck),
    .serial_input_pin     (si),
    .serial_output_pin    (so),
    .serial_output_pin_oe (so_oe),
    .busy                 (busy),
    .irq                  (irq)
  );

  // open-drain capable line, pulled up when released
  assign so_wire = so_oe ? so : 1'h1;

  serial_peer_model i_serial_peer_model (
    .clk     (clk),
    .sck     (sck),
    .so      (so_wire),
    .arm     (arm),
    .tx_byte (ptx),
    .si      (si),
    .rx_byte (prx),
    .period  (period)
  );

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // prescaler tick every 8 clocks
  always @(posedge clk) begin
    pc <= pc + 3'h1;
    prescaler_tick <= (pc == 3'h7);
  end

  task automatic chk(input string n, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] v);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 d = rd_data;
    @(posedge clk);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'h0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000)
      chk("busy", 16'(busy), 16'h0);
  endtask

  task automatic start;
    arm <= 1'h1;
    @(posedge clk);
    arm <= 1'h0;
    wr(serial_port_pkg::ADDR_START, 4'h0);
    #1 chk("busy", 16'(busy), 16'h1);
  endtask

  task automatic xfer(input logic [7:0] t, input logic [1:0] f,
                      input logic dv, idl, pm);
    wr(serial_port_pkg::ADDR_PIN_FUNC, {2'h0, f});
    wr(serial_port_pkg::ADDR_MISC, {1'h0, pm, 2'h0});
    wr(serial_port_pkg::ADDR_MODE_B, {2'h0, idl, dv});
    wr(serial_port_pkg::ADDR_DATA_LO, t[3:0]);
    wr(serial_port_pkg::ADDR_DATA_HI, t[7:4]);
    start();
    wr(serial_port_pkg::ADDR_MODE_B, {2'h0, ~idl, ~dv});
    wait_idle(); // mode B write left alone while busy
    repeat (3) @(posedge clk);
    #1 chk("rx", 16'(prx), f[0] ? 16'(t) : 16'hFF);
    chk("period", period, dv ? 16'h20 : 16'h10);
    chk("oe", 16'(so_oe), 16'(f[0] & ~(pm & idl)));
    if (f[0])
      chk("idle", 16'(so), 16'(idl));
    chk("irq", 16'(irq), 16'h1);
    rd(serial_port_pkg::ADDR_IRQ_STAT);
    chk("stat", 16'(d), 16'h1);
    #1 chk("irq clr", 16'(irq), 16'h0);
    rd(serial_port_pkg::ADDR_DATA_LO);
    lo = d;
    rd(serial_port_pkg::ADDR_DATA_HI);
    chk("rd", 16'({d, lo}), f[1] ? 16'(ptx) : 16'h0);
  endtask

  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    $display("[FAIL] watchdog expected end seen hang");
    end_sim();
  end

  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    stop_mode = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    arm = 1'h0;
    addr = 8'h0;
    wr_data = 4'h0;
    pc = 3'h0;
    prescaler_tick = 1'h0;
    ptx = 8'h0;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(58334));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1 chk("oe rst", 16'(so_oe), 16'h0);
    chk("sck rst", 16'(sck), 16'h1);
    wr(serial_port_pkg::ADDR_IRQ_MASK, 4'h1);
    rd(serial_port_pkg::ADDR_IRQ_MASK);
    chk("mask", 16'(d), 16'h1);
    rd(8'h3F);
    chk("unmapped", 16'(d), 16'h0);
    wr(serial_port_pkg::ADDR_DATA_LO, 4'hA);
    rd(serial_port_pkg::ADDR_DATA_LO);
    chk("lo rw", 16'(d), 16'hA);
    ptx = 8'h80;
    xfer(8'h01, 2'h3, 1'h0, 1'h1, 1'h1);
    ptx = 8'h5A;
    xfer(8'hC3, 2'h1, 1'h1, 1'h0, 1'h1);
    for (int i = 0; i < 6; i++) begin
      ptx = 8'($urandom);
      xfer(8'($urandom), 2'($urandom), 1'($urandom), 1'($urandom),
           1'($urandom));
    end
    // abort mid-transfer through mode A
    start();
    repeat (40) @(posedge clk);
    wr(serial_port_pkg::ADDR_MODE_A, 4'h0);
    #1 chk("abort busy", 16'(busy), 16'h0);
    rd(serial_port_pkg::ADDR_IRQ_STAT);
    chk("abort stat", 16'(d), 16'h1);
    // stop mode clears divisor, pin function and misc
    wr(serial_port_pkg::ADDR_MODE_B, 4'h3);
    wr(serial_port_pkg::ADDR_MISC, 4'h4);
    wr(serial_port_pkg::ADDR_PIN_FUNC, 4'h1);
    // stop mode lands mid-transfer, so the abort path is taken too
    start();
    repeat (20) @(posedge clk);
    stop_mode <= 1'h1;
    @(posedge clk);
    stop_mode <= 1'h0;
    #1 chk("stop busy", 16'(busy), 16'h0);
    rd(serial_port_pkg::ADDR_IRQ_STAT);
    chk("stop stat", 16'(d), 16'h1);
    repeat (2) @(posedge clk);
    #1 chk("oe stop", 16'(so_oe), 16'h0);
    wr(serial_port_pkg::ADDR_PIN_FUNC, 4'h1);
    #1 chk("pmos stop", 16'(so_oe), 16'h1);
    start();
    // frozen clock enable must hold the transfer far past its length
    ce <= 1'h0;
    repeat (300) @(posedge clk);
    #1 chk("freeze", 16'(busy), 16'h1);
    ce <= 1'h1;
    wait_idle();
    repeat (3) @(posedge clk);
    #1 chk("div stop", period, 16'h10);
    end_sim();
  end
endmodule
